/* File: src/cwg_pkg.sv */
package cwg_pkg;
  // ==========================================================
  // Register map
  localparam logic [7:0] CWG_CONTROL0_OFF    = 8'h00;
  localparam logic [7:0] CWG_CONTROL1_OFF    = 8'h04;
  localparam logic [7:0] CWG_CLOCK_CTL_OFF   = 8'h08;
  localparam logic [7:0] CWG_INPUT_SEL_OFF   = 8'h0c;
  localparam logic [7:0] CWG_RISE_DB_OFF     = 8'h10;
  localparam logic [7:0] CWG_FALL_DB_OFF     = 8'h14;
  localparam logic [7:0] CWG_SHUTDOWN0_OFF   = 8'h18;
  localparam logic [7:0] CWG_STEER_OFF       = 8'h1c;
  localparam logic [7:0] CWG_STATUS_OFF      = 8'h20;
  // ==========================================================
  // Field positions
  localparam int CWG_C0_EN_BIT   = 7;
  localparam int CWG_C0_LOAD_BIT = 6;
  localparam int CWG_C0_MODE_LSB = 0;
  localparam int CWG_C1_POL_LSB  = 0;
  localparam int CWG_C1_OE_LSB   = 4;
  localparam int CWG_AS_SHUT_BIT = 7;
  localparam int CWG_AS_REN_BIT  = 6;
  localparam int CWG_AS_OVR_LSB  = 0;
  localparam int CWG_AS_ASEN_BIT = 4;
  localparam int CWG_DB_W        = 6;
  localparam int CWG_NUM_SRC     = 9;
  localparam logic [3:0] CWG_ISM_MAX = 4'h8;
  // ==========================================================
  // Reset values
  localparam logic [31:0] CWG_RESET_WORD = 32'h0000_0000;
  // ==========================================================
  // Modes
  typedef enum logic [2:0] {
    CWG_M_STEER_IMM  = 3'h0,
    CWG_M_STEER_SYNC = 3'h1,
    CWG_M_FB_FWD     = 3'h2,
    CWG_M_FB_REV     = 3'h3,
    CWG_M_HALF       = 3'h4,
    CWG_M_PUSHPULL   = 3'h5
  } cwg_mode_t;
  // ==========================================================
  // Input sources
  typedef struct packed {
    logic pin;
    logic comparator1_synced;
    logic comparator2_synced;
    logic capcomp1_output;
    logic capcomp2_output;
    logic logic_cell1_output;
    logic logic_cell2_output;
    logic pulse_unit3_output;
    logic pulse_unit4_output;
  } cwg_src_t;
  typedef struct packed {
    logic out_fourth;
    logic out_third;
    logic out_second;
    logic out_first;
  } cwg_out_t;
endpackage : cwg_pkg

/* File: src/cwg_top.sv */
// Summary of operation
// RULE1 - Six modes chosen by the mode field of control register zero.
// RULE2 - Half-bridge drives true and inverted input copies with dead band between.
// RULE3 - Half-bridge third and fourth outputs repeat the pair, own polarity.
// RULE4 - Push-pull sends successive input pulses alternately to first and second.
// RULE5 - Push-pull sequencer resets when disabled or shut down.
// RULE6 - Sequencer advances per pulse; first pulse after reset goes to first.
// RULE7 - Push-pull third copies first, fourth copies second, own polarity.
// RULE8 - Forward bridge: first active, second third inactive, fourth modulated.
// RULE9 - Reverse bridge: third active, first fourth inactive, second modulated.
// RULE10 - Full-bridge uses dead band only on a direction change.
// RULE11 - Direction may flip by mode bit zero while enabled.
// RULE12 - Steering routes input to any subset of the four outputs.
// RULE13 - Synchronous steering update takes effect at next input rising edge.
// RULE14 - Immediate steering update takes effect the cycle after the write.
// RULE15 - Clock-select bit picks system clock or 16 MHz oscillator.
// RULE16 - Input select picks one of nine waveform sources.
// RULE17 - Per-output enable: clear leaves pin alone, set drives it.
// RULE18 - With module disabled, output enables and levels have no effect.
// RULE19 - Per-output polarity bit: set active-high, clear active-low.
// RULE20 - Polarity does not change override levels, shutdown or steering.
// RULE21 - Two 6-bit dead-band counters: rise/reverse and fall/forward.
// RULE22 - Dead band counts generator clock periods from zero to register value.
// RULE23 - Half-bridge dead band delays inverted rise after true fall.
// RULE24 - Dead-band values double-buffered; load now if disabled, else on falling edge.
// RULE25 - Mode 000 immediate steering, 001 synchronous steering.
// RULE26 - Software shutdown forces shutdown; auto-restart clears it at next rise.
// RULE27 - Auto-shutdown works in every mode.
// RULE28 - Counters run on the generator clock enable; input synchronised first.
//
// The AHB-Lite register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module cwg_top #(
  parameter int OSC_DIV = 16  // mclk cycles per oscillator tick (250/16 MHz)
) (
  input  wire logic        mclk,         // 250 MHz clock
  input  wire logic        rst_b,        // Async reset, active low
  input  wire logic [31:0] haddr,        // AHB address
  input  wire logic [1:0]  htrans,       // AHB transfer type
  input  wire logic        hwrite,       // AHB write
  input  wire logic [2:0]  hsize,        // AHB size
  input  wire logic [31:0] hwdata,       // AHB write data
  input  wire logic        hsel,         // AHB select
  input  wire logic        hready,       // AHB bus ready
  output logic      [31:0] hrdata,       // AHB read data
  output logic             hreadyout,    // AHB slave ready
  output logic             hresp,        // AHB response
  input  wire cwg_pkg::cwg_src_t src_in, // Waveform sources
  input  wire logic        shutdown_n,   // External fault, active low
  output var cwg_pkg::cwg_out_t out_level, // Output pin levels
  output var cwg_pkg::cwg_out_t out_oe     // Output pin enables
);
  import cwg_pkg::*;

  if (OSC_DIV < 1 || OSC_DIV > 256) begin : g_div_check
    $error("OSC_DIV must be 1 to 256");
  end

  // ==========================================================
  // Registers
  logic [7:0] ctl0_r, ctl1_r, clk_r, ism_r, shut_r, steer_r;
  logic [5:0] dbr_r, dbf_r, dbr_buf_r, dbf_buf_r;
  logic       wr_ph_r;
  logic [7:0] wa_r;
  logic       en;
  cwg_mode_t  mode;
  logic       tick;
  logic       din_rise, din_fall;
  logic       shut_act;

  assign en   = ctl0_r[CWG_C0_EN_BIT];
  assign mode = cwg_mode_t'(ctl0_r[CWG_C0_MODE_LSB +: 3]); // RULE1 RULE25

  // ==========================================================
  // AHB-Lite slave, zero wait states
  logic acc;
  assign acc = hsel & hready & htrans[1];

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ph_r <= 1'b0;
      wa_r    <= 8'h00;
    end else if (hready) begin
      wr_ph_r <= acc & hwrite;
      wa_r    <= haddr[7:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      hrdata    <= CWG_RESET_WORD;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (acc && !hwrite) begin
        unique case (haddr[7:0])
          CWG_CONTROL0_OFF:  hrdata <= {24'h0, ctl0_r};
          CWG_CONTROL1_OFF:  hrdata <= {24'h0, ctl1_r};
          CWG_CLOCK_CTL_OFF: hrdata <= {24'h0, clk_r};
          CWG_INPUT_SEL_OFF: hrdata <= {24'h0, ism_r};
          CWG_RISE_DB_OFF:   hrdata <= {26'h0, dbr_r};
          CWG_FALL_DB_OFF:   hrdata <= {26'h0, dbf_r};
          CWG_SHUTDOWN0_OFF: hrdata <= {24'h0, shut_r};
          CWG_STEER_OFF:     hrdata <= {24'h0, steer_r};
          CWG_STATUS_OFF:    hrdata <= {26'h0, dbr_buf_r};
          default:           hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  logic wr0, wr_dbr, wr_dbf, wr_sh;
  assign wr0    = wr_ph_r && wa_r == CWG_CONTROL0_OFF;
  assign wr_dbr = wr_ph_r && wa_r == CWG_RISE_DB_OFF;
  assign wr_dbf = wr_ph_r && wa_r == CWG_FALL_DB_OFF;
  assign wr_sh  = wr_ph_r && wa_r == CWG_SHUTDOWN0_OFF;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ctl1_r  <= 8'h00;
      clk_r   <= 8'h00;
      ism_r   <= 8'h00;
      steer_r <= 8'h00;
      dbr_r   <= 6'h00;
      dbf_r   <= 6'h00;
    end else if (wr_ph_r) begin
      unique case (wa_r)
        CWG_CONTROL1_OFF:  ctl1_r  <= hwdata[7:0];
        CWG_CLOCK_CTL_OFF: clk_r   <= {7'h0, hwdata[0]};
        CWG_INPUT_SEL_OFF: ism_r   <= (hwdata[3:0] > CWG_ISM_MAX) ? 8'h00 : {4'h0, hwdata[3:0]};
        CWG_STEER_OFF:     steer_r <= hwdata[7:0];
        CWG_RISE_DB_OFF:   dbr_r   <= hwdata[5:0];
        CWG_FALL_DB_OFF:   dbf_r   <= hwdata[5:0];
        default: ;
      endcase
    end
  end

  // Control 0: load bit clears itself at falling input edge
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ctl0_r <= 8'h00;
    end else if (wr0) begin
      ctl0_r <= hwdata[7:0];
    end else if (din_fall) begin
      ctl0_r[CWG_C0_LOAD_BIT] <= 1'b0;
    end
  end

  // ==========================================================
  // Dead-band double buffer
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      dbr_buf_r <= 6'h00;
      dbf_buf_r <= 6'h00;
    end else if (!en) begin
      dbr_buf_r <= wr_dbr ? hwdata[5:0] : dbr_r; // RULE24
      dbf_buf_r <= wr_dbf ? hwdata[5:0] : dbf_r; // RULE24
    end else if (ctl0_r[CWG_C0_LOAD_BIT] && din_fall) begin
      dbr_buf_r <= dbr_r; // RULE24
      dbf_buf_r <= dbf_r; // RULE24
    end
  end

  // ==========================================================
  // Generator clock enable
  logic [7:0] div_r;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      div_r <= 8'h00;
    end else if (div_r == 8'(OSC_DIV - 1)) begin
      div_r <= 8'h00;
    end else begin
      div_r <= div_r + 8'h01;
    end
  end
  assign tick = clk_r[0] ? (div_r == 8'h00) : 1'b1; // RULE15

  // ==========================================================
  // Input select and synchroniser
  logic [CWG_NUM_SRC-1:0] srcv, sy1_r, sy2_r;
  logic                   sel_in, din_r;
  assign srcv   = src_in;
  assign sel_in = sy2_r[CWG_NUM_SRC - 1 - int'(ism_r[3:0])]; // RULE16
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sy1_r <= '0;
      sy2_r <= '0;
      din_r <= 1'b0;
    end else begin
      sy1_r <= srcv; // RULE28
      sy2_r <= sy1_r;
      din_r <= sel_in;
    end
  end
  // Edges seen a cycle before din_r moves, so dead band masks at once
  assign din_rise = sel_in & ~din_r;
  assign din_fall = ~sel_in & din_r;

  // ==========================================================
  // Shutdown
  logic sd1_r, sd2_r;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sd1_r <= 1'b1;
      sd2_r <= 1'b1;
    end else begin
      sd1_r <= shutdown_n;
      sd2_r <= sd1_r;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      shut_r <= 8'h00;
    end else if (wr_sh) begin
      shut_r <= hwdata[7:0];
    end else if (shut_r[CWG_AS_REN_BIT] && din_rise && sd2_r) begin
      shut_r[CWG_AS_SHUT_BIT] <= 1'b0; // RULE26
    end
  end
  assign shut_act = shut_r[CWG_AS_SHUT_BIT] | (shut_r[CWG_AS_ASEN_BIT] & ~sd2_r); // RULE26 RULE27

  // ==========================================================
  // Push-pull sequencer
  logic pp_r;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pp_r <= 1'b0;
    end else if (!en || shut_act) begin
      pp_r <= 1'b0; // RULE5
    end else if (din_fall && mode == CWG_M_PUSHPULL) begin
      pp_r <= ~pp_r; // RULE4 RULE6
    end
  end

  // ==========================================================
  // Dead-band counters on generator clock
  logic [5:0] rcnt_r, fcnt_r;
  logic       rbusy_r, fbusy_r, dir_r, dirchg_r;
  logic       fb_mode, fstart;
  assign fb_mode = mode == CWG_M_FB_FWD || mode == CWG_M_FB_REV;
  // Full bridge times the forward dead band from the input rise
  assign fstart  = fb_mode ? din_rise : din_fall;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      dir_r    <= 1'b0;
      dirchg_r <= 1'b0;
    end else if (din_rise) begin
      dirchg_r <= fb_mode && (mode[0] != dir_r); // RULE10 RULE11
      if (fb_mode) dir_r <= mode[0];
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rcnt_r  <= 6'h00;
      rbusy_r <= 1'b0;
    end else if (din_rise) begin
      rcnt_r  <= 6'h00; // RULE22
      rbusy_r <= dbr_buf_r != 6'h00;
    end else if (rbusy_r && tick) begin
      rcnt_r  <= rcnt_r + 6'h01; // RULE21 RULE28
      rbusy_r <= (rcnt_r + 6'h01) != dbr_buf_r;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      fcnt_r  <= 6'h00;
      fbusy_r <= 1'b0;
    end else if (fstart) begin
      fcnt_r  <= 6'h00; // RULE22
      fbusy_r <= dbf_buf_r != 6'h00;
    end else if (fbusy_r && tick) begin
      fcnt_r  <= fcnt_r + 6'h01; // RULE21 RULE28
      fbusy_r <= (fcnt_r + 6'h01) != dbf_buf_r;
    end
  end

  // ==========================================================
  // Steering latch
  logic [3:0] str_r;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      str_r <= 4'h0;
    end else if (mode == CWG_M_STEER_SYNC) begin
      if (din_rise) str_r <= steer_r[3:0]; // RULE13
    end else begin
      str_r <= steer_r[3:0]; // RULE14
    end
  end

  // ==========================================================
  // Waveform generation, active-high before polarity
  logic       din;
  logic [3:0] act;
  always_comb begin
    din = din_r;
    act = 4'h0;
    unique case (mode)
      CWG_M_HALF: begin
        act[0] = din & ~rbusy_r;              // RULE2
        act[1] = ~din & ~fbusy_r;             // RULE2 RULE23
        act[2] = act[0];                      // RULE3
        act[3] = act[1];                      // RULE3
      end
      CWG_M_PUSHPULL: begin
        act[0] = din & ~pp_r;                 // RULE4
        act[1] = din & pp_r;                  // RULE4
        act[2] = act[0];                      // RULE7
        act[3] = act[1];                      // RULE7
      end
      CWG_M_FB_FWD: begin
        act[0] = 1'b1;                        // RULE8
        act[3] = din & ~(dirchg_r & fbusy_r); // RULE8 RULE10
      end
      CWG_M_FB_REV: begin
        act[2] = 1'b1;                        // RULE9
        act[1] = din & ~(dirchg_r & rbusy_r); // RULE9 RULE10
      end
      CWG_M_STEER_IMM, CWG_M_STEER_SYNC: begin
        act = str_r & {4{din}};               // RULE12
      end
      default: act = 4'h0;
    endcase
  end

  // ==========================================================
  // Output stage
  logic [3:0] pol, oe_bits, ovr, lvl_nxt, oe_nxt;
  assign pol     = ctl1_r[CWG_C1_POL_LSB +: 4];
  assign oe_bits = ctl1_r[CWG_C1_OE_LSB +: 4];
  assign ovr     = shut_r[CWG_AS_OVR_LSB +: 4];

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (shut_act && (mode > CWG_M_STEER_SYNC || str_r[i])) begin
        lvl_nxt[i] = ovr[i]; // RULE20 RULE27
      end else if ((mode == CWG_M_STEER_IMM || mode == CWG_M_STEER_SYNC) && !str_r[i]) begin
        lvl_nxt[i] = steer_r[4 + i]; // RULE20
      end else begin
        lvl_nxt[i] = pol[i] ? act[i] : ~act[i]; // RULE19
      end
      oe_nxt[i] = en & oe_bits[i]; // RULE17 RULE18
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      out_level <= '0;
      out_oe    <= '0;
    end else begin
      out_level <= en ? cwg_out_t'(lvl_nxt) : '0; // RULE18
      out_oe    <= cwg_out_t'(oe_nxt);
    end
  end

  // ==========================================================
  // Checks
  a_oe_needs_en: assert property (@(posedge mclk) disable iff (!rst_b)
    !en |=> out_oe == '0) else $error("Output enabled while module off"); // RULE18
  a_pp_reset: assert property (@(posedge mclk) disable iff (!rst_b)
    (!en || shut_act) |=> !pp_r) else $error("Push-pull not reset"); // RULE5
  a_fwd_levels: assert property (@(posedge mclk) disable iff (!rst_b)
    (en && !shut_act && mode == CWG_M_FB_FWD && pol[0] && !pol[2] && $stable(ctl1_r))
    |=> out_level.out_first && out_level.out_third) else $error("Forward bridge statics wrong"); // RULE8
  a_rev_levels: assert property (@(posedge mclk) disable iff (!rst_b)
    (en && !shut_act && mode == CWG_M_FB_REV && pol[2] && !pol[0] && $stable(ctl1_r))
    |=> out_level.out_third && out_level.out_first) else $error("Reverse bridge statics wrong"); // RULE9
  a_sync_steer: assert property (@(posedge mclk) disable iff (!rst_b)
    (mode == CWG_M_STEER_SYNC && !din_rise) |=> $stable(str_r)) else $error("Steering moved off edge"); // RULE13
  a_imm_steer: assert property (@(posedge mclk) disable iff (!rst_b)
    (mode == CWG_M_STEER_IMM) |=> str_r == $past(steer_r[3:0])) else $error("Immediate steering late"); // RULE14
  a_db_bound: assert property (@(posedge mclk) disable iff (!rst_b)
    rbusy_r |-> rcnt_r < dbr_buf_r) else $error("Rise dead band overran"); // RULE22
  a_half_gap: assert property (@(posedge mclk) disable iff (!rst_b)
    (mode == CWG_M_HALF && din_fall && dbf_buf_r != 6'h00) |=> fbusy_r && act[1] == 1'b0)
    else $error("Half-bridge inverted rose without dead band"); // RULE23
  a_sw_shut: assert property (@(posedge mclk) disable iff (!rst_b)
    (shut_r[CWG_AS_SHUT_BIT] && !shut_r[CWG_AS_REN_BIT] && !wr_sh) |=> shut_r[CWG_AS_SHUT_BIT])
    else $error("Shutdown cleared without restart"); // RULE26
endmodule : cwg_top
`default_nettype wire

/* File: bench/cwg_gate_drv.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Gate driver inputs seen from the power stage
module cwg_gate_drv (
  input  wire cwg_pkg::cwg_out_t level,  // Levels from generator
  input  wire cwg_pkg::cwg_out_t oe,     // Drive enables from generator
  output logic [3:0]             gate    // Gate driver inputs
);
  import cwg_pkg::*;
  // Undriven gate inputs sit on their pull-down
  assign gate = 4'(level) & 4'(oe);
endmodule : cwg_gate_drv
`default_nettype wire

/* File: bench/cwg_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module cwg_top_tb;
  import cwg_pkg::*;
  logic        mclk, rst_b, hwrite, hsel, hreadyout, hresp, shutdown_n, ph;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  pin_level, pol, steer_en, steer_lvl;
  cwg_src_t    src_in;
  cwg_out_t    out_level, out_oe;
  int          n_mismatch, checked, cycles, seed, isel, k;

  cwg_top #(.OSC_DIV(2)) dut (
    .mclk(mclk), .rst_b(rst_b), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hsel(hsel), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .src_in(src_in), .shutdown_n(shutdown_n),
    .out_level(out_level), .out_oe(out_oe)
  );
  cwg_gate_drv u_gate (.level(out_level), .oe(out_oe), .gate(pin_level));

  initial mclk = 1'b0;
  always #2 mclk = ~mclk;

  // ==========================================================
  // Bus master and comparisons
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    haddr  <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize  <= 3'h2;
    hsel   <= 1'h1;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask : wr
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: word got %h expected %h", $time, got, exp);
    end
  endtask : chk_word
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge mclk);
    bus(a, 1'b0, 32'h0);
    chk_word(rd, exp);
  endtask : rdchk
  task automatic chk_out(input logic [3:0] exp, input logic [3:0] oe);
    checked++;
    if (4'(out_oe) !== oe || pin_level !== (exp & oe)) begin
      n_mismatch++;
      $display("mismatch at %0t: pins %h oe %h expected %h oe %h", $time, pin_level, out_oe, exp & oe, oe);
    end
  endtask : chk_out
  task automatic drive(input logic v);
    logic [8:0] s;
    s = 9'($random(seed));
    s[8 - isel] = v;
    @(posedge mclk);
    src_in <= s;
    repeat (12) @(posedge mclk);
  endtask : drive
  task automatic fall_gap(output int n);
    src_in[8] <= 1'b0;
    n = 0;
    do begin @(posedge mclk); n++; end while (out_level.out_first !== 1'b0 && n < 20);
    n = 0;
    do begin @(posedge mclk); n++; end while (out_level.out_second !== 1'b1 && n < 40);
  endtask : fall_gap
  task automatic end_of_test;
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_of_test

  // ==========================================================
  // Reference model of steady pin levels
  function automatic logic [3:0] model(input int m, input logic d);
    logic [3:0] a;
    case (m)
      0, 1: return (({4{d}} ~^ pol) & steer_en) | (steer_lvl & ~steer_en);
      2: a = {d, 2'b00, 1'b1};
      3: a = {1'b0, 1'b1, d, 1'b0};
      4: a = {~d, d, ~d, d};
      5: a = {d & ph, d & ~ph, d & ph, d & ~ph};
      default: a = 4'h0;
    endcase
    return a ~^ pol;
  endfunction : model

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    rst_b = 1'b0;
    seed = 25;
    {haddr, hwdata, htrans, hwrite, hsize, hsel, src_in, ph, isel} = '0;
    shutdown_n = 1'b1;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    chk_out(4'h0, 4'h0);
    for (int a = 0; a <= 9; a++) rdchk(8'(a * 4), CWG_RESET_WORD);
    wr(CWG_INPUT_SEL_OFF, 32'h9);
    rdchk(CWG_INPUT_SEL_OFF, 32'h0);
    wr(CWG_CONTROL1_OFF, 32'hff);
    repeat (4) @(posedge mclk);
    chk_out(4'h0, 4'h0);
    wr(CWG_RISE_DB_OFF, 32'h3);
    wr(CWG_FALL_DB_OFF, 32'h3);
    rdchk(CWG_STATUS_OFF, 32'h3);
    // Every source under immediate steering, random polarity
    for (isel = 0; isel < CWG_NUM_SRC; isel++) begin
      {steer_lvl, steer_en, pol} = 12'($random(seed));
      wr(CWG_INPUT_SEL_OFF, 32'(isel));
      wr(CWG_CONTROL1_OFF, {24'h0, 4'hf, pol});
      wr(CWG_STEER_OFF, {24'h0, steer_lvl, steer_en});
      wr(CWG_CONTROL0_OFF, 32'h80);
      drive(1'b1);
      chk_out(model(0, 1'b1), 4'hf);
      drive(1'b0);
      chk_out(model(0, 1'b0), 4'hf);
    end
    isel = 0;
    wr(CWG_INPUT_SEL_OFF, 32'h0);
    // Bridge modes, direction flipped while running
    for (int m = 2; m <= 4; m++) begin
      pol = 4'($random(seed));
      wr(CWG_CONTROL1_OFF, {24'h0, 4'hf, pol});
      wr(CWG_CONTROL0_OFF, 32'h80 | 32'(m));
      drive(1'b1);
      chk_out(model(m, 1'b1), 4'hf);
      drive(1'b0);
      chk_out(model(m, 1'b0), 4'hf);
    end
    // Direction flip holds the modulated output for the dead band
    wr(CWG_CONTROL1_OFF, 32'hff);
    wr(CWG_CONTROL0_OFF, 32'h82);
    drive(1'b1);
    drive(1'b0);
    wr(CWG_CONTROL0_OFF, 32'h83);
    src_in[8] <= 1'b1;
    k = 0;
    do begin @(posedge mclk); k++; end while (out_level.out_second !== 1'b1 && k < 40);
    chk_word(32'(k == 8), 32'h1);
    // Half-bridge dead band after the true output falls
    pol = 4'hf;
    wr(CWG_CONTROL1_OFF, 32'hff);
    wr(CWG_CONTROL0_OFF, 32'h04);
    wr(CWG_FALL_DB_OFF, 32'h5);
    wr(CWG_CONTROL0_OFF, 32'h84);
    drive(1'b1);
    fall_gap(k);
    chk_word(32'(k >= 5 && k <= 7), 32'h1);
    // Oscillator tick stretches the same dead band
    wr(CWG_CLOCK_CTL_OFF, 32'h1);
    drive(1'b1);
    fall_gap(k);
    chk_word(32'(k >= 9 && k <= 10), 32'h1);
    wr(CWG_CLOCK_CTL_OFF, 32'h0);
    // Buffered dead band waits for load request and a falling input
    wr(CWG_RISE_DB_OFF, 32'h7);
    rdchk(CWG_STATUS_OFF, 32'h3);
    wr(CWG_CONTROL0_OFF, 32'hc4);
    drive(1'b1);
    drive(1'b0);
    rdchk(CWG_STATUS_OFF, 32'h7);
    rdchk(CWG_CONTROL0_OFF, 32'h84);
    // Push-pull alternation and restart on disable
    wr(CWG_CONTROL0_OFF, 32'h05);
    wr(CWG_CONTROL0_OFF, 32'h85);
    ph = 1'b0;
    for (int p = 0; p < 3; p++) begin
      drive(1'b1);
      chk_out(model(5, 1'b1), 4'hf);
      drive(1'b0);
      ph = ~ph;
    end
    wr(CWG_CONTROL0_OFF, 32'h05);
    wr(CWG_CONTROL0_OFF, 32'h85);
    ph = 1'b0;
    drive(1'b1);
    chk_out(model(5, 1'b1), 4'hf);
    drive(1'b0);
    // Synchronous then immediate steering updates
    {steer_en, steer_lvl} = 8'h00;
    wr(CWG_STEER_OFF, 32'h0);
    wr(CWG_CONTROL0_OFF, 32'h81);
    drive(1'b1);
    wr(CWG_STEER_OFF, 32'h0f);
    repeat (8) @(posedge mclk);
    chk_out(4'h0, 4'hf);
    drive(1'b0);
    drive(1'b1);
    chk_out(4'hf, 4'hf);
    wr(CWG_CONTROL0_OFF, 32'h80);
    wr(CWG_STEER_OFF, 32'h05);
    repeat (3) @(posedge mclk);
    chk_out(4'h5, 4'hf);
    // Software shutdown, polarity, auto-restart, external fault
    wr(CWG_CONTROL0_OFF, 32'h82);
    wr(CWG_SHUTDOWN0_OFF, 32'h8a);
    repeat (4) @(posedge mclk);
    chk_out(4'ha, 4'hf);
    wr(CWG_CONTROL1_OFF, 32'hf0);
    repeat (4) @(posedge mclk);
    chk_out(4'ha, 4'hf);
    wr(CWG_SHUTDOWN0_OFF, 32'hca);
    drive(1'b0);
    drive(1'b1);
    rdchk(CWG_SHUTDOWN0_OFF, 32'h4a);
    wr(CWG_SHUTDOWN0_OFF, 32'h1a);
    shutdown_n <= 1'b0;
    repeat (8) @(posedge mclk);
    chk_out(4'ha, 4'hf);
    shutdown_n <= 1'b1;
    wr(CWG_SHUTDOWN0_OFF, 32'h0);
    pol = 4'hf;
    wr(CWG_CONTROL1_OFF, 32'h5f);
    drive(1'b0);
    drive(1'b1);
    chk_out(model(2, 1'b1), 4'h5);
    end_of_test();
  end
endmodule : cwg_top_tb
`default_nettype wire
